// *** fbci_bus_cycle.sv ***
`timescale 1ns/1ps
`default_nettype none

module fbci_bus_cycle (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic req_valid,
    input wire fbci_pkg::fbci_req_t req,
    output logic done,
    output logic [fbci_pkg::DATA_W-1:0] rdata,
    output logic ce_n,
    output logic oe_n,
    output logic we_n,
    output logic [fbci_pkg::ADDR_W-1:0] addr,
    output logic [fbci_pkg::DATA_W-1:0] dq_out,
    output logic dq_oe,
    input wire logic [fbci_pkg::DATA_W-1:0] dq_in
);

    typedef enum logic [1:0] {E_IDLE, E_SETUP, E_STROBE, E_HOLD} fbci_eng_t;

    fbci_eng_t state;
    logic is_wr;
    logic [fbci_pkg::CNT_W-1:0] cnt;
    logic [fbci_pkg::CNT_W-1:0] limit;

    assign limit = is_wr ? fbci_pkg::CNT_W'(fbci_pkg::WE_PULSE_CYC) : fbci_pkg::CNT_W'(fbci_pkg::ACCESS_CYC);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= E_IDLE;
            is_wr <= 1'b0;
            cnt <= '0;
        end else begin
            case (state)
                E_IDLE: begin
                    if (req_valid) begin
                        is_wr <= req.wr;
                        state <= E_SETUP;
                    end
                end
                E_SETUP: begin
                    cnt <= fbci_pkg::CNT_W'(1);
                    state <= E_STROBE;
                end
                E_STROBE: begin
                    if (cnt == limit) begin
                        state <= E_HOLD;
                    end else begin
                        cnt <= cnt + fbci_pkg::CNT_W'(1);
                    end
                end
                default: state <= E_IDLE;
            endcase
        end
    end

    // Pin sequencing; only one strobe is ever low, so reads never overlap writes
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ce_n <= 1'b1;
            oe_n <= 1'b1;
            we_n <= 1'b1;
            addr <= '0;
            dq_out <= '0;
            dq_oe <= 1'b0;
        end else begin
            case (state)
                E_IDLE: begin
                    if (req_valid) begin
                        addr <= req.addr;
                        dq_out <= req.data;
                    end
                end
                E_SETUP: begin
                    ce_n <= 1'b0;
                    dq_oe <= is_wr;
                    oe_n <= is_wr;
                    we_n <= !is_wr;
                end
                E_STROBE: begin
                    if (cnt == limit) begin
                        oe_n <= 1'b1;
                        we_n <= 1'b1;
                    end
                end
                default: begin
                    ce_n <= 1'b1;
                    dq_oe <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            done <= 1'b0;
            rdata <= '0;
        end else begin
            done <= (state == E_HOLD);
            if (state == E_STROBE && cnt == limit && !is_wr) begin
                rdata <= dq_in;
            end
        end
    end

endmodule

`default_nettype wire

// *** fbci_flash_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Identifier values are arbitrary
module fbci_flash_model #(
    parameter logic [15:0] MAKER = 16'h0011,
    parameter logic [15:0] DEVICE = 16'h0022,
    parameter int TICKS = 30
) (
    input wire logic [18:0] addr,
    input wire logic [15:0] hdq,
    input wire logic hoe,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic rp_n,
    input wire logic vpp,
    output logic [15:0] dq
);
    logic [15:0] mem [16];
    logic [15:0] last, wd;
    logic [5:0] err;
    logic [1:0] mode, pend;
    logic busy, susp, ers;
    logic [3:0] wa;
    int left;
    wire logic on = rp_n && !ce_n && !oe_n && we_n;
    wire logic [7:0] sr = {!busy || susp, susp, err};
    wire logic [15:0] rdat = mode == 2'd2 ? {8'h00, sr} : mode == 2'd1 ? (addr[0] ? DEVICE : MAKER) : mem[addr[3:0]];
    // drive on reads
    // Floating lines show the inverse of the last value, never a stale copy
    assign dq = hoe ? hdq : on ? rdat : ~last;
    always @(on or rdat or hoe or hdq) begin
        if (hoe)
            last = hdq;
        else if (on)
            last = rdat;
    end
    task automatic pdown;
        busy = 1'b0;
        susp = 1'b0;
        pend = 2'd0;
        mode = 2'd0;
        err = 6'h00;
    endtask
    task automatic start(input logic e);
        busy = 1'b1;
        ers = e;
        left = TICKS;
    endtask
    initial begin
        for (int i = 0; i < 16; i++)
            mem[i] = 16'ha500 + 16'(i);
        pdown();
    end
    always @(negedge rp_n) pdown();
    always @(posedge we_n or posedge ce_n) if (rp_n && (!we_n || !ce_n)) begin
        if (pend == 2'd1) begin
            pend = 2'd0;
            // erase confirm; lockout flags supply and erase
            if (dq[7:0] != 8'hd0)
                err[5:4] = 2'b11;
            else if (vpp)
                start(1'b1);
            else
                err = err | 6'h28;
        end else if (pend == 2'd2) begin
            pend = 2'd0;
            wa = addr[3:0];
            wd = dq;
            if (vpp)
                start(1'b0);
            else
                err[4:3] = 2'b11;
        end else begin
            case (dq[7:0])
                8'hff: if (!busy || susp) mode = 2'd0;
                8'h90: mode = 2'd1;
                8'h70: mode = 2'd2;
                8'h50: if (!susp) err = 6'h00;
                8'h20: pend = 2'd1;
                8'h40, 8'h10: pend = 2'd2;
                8'hb0: if (busy) susp = 1'b1;
                8'hd0: susp = 1'b0;
                default: ;
            endcase
            if (pend != 2'd0)
                mode = 2'd2;
        end
    end
    always #100 if (busy && !susp) begin
        left--;
        if (left == 0) begin
            busy = 1'b0;
            if (ers)
                for (int i = 0; i < 16; i++)
                    mem[i] = 16'hffff;
            else
                mem[wa] = wd;
        end
    end
endmodule
`default_nettype wire

// *** fbci_host.sv ***
`timescale 1ns/1ps
`default_nettype none

module fbci_host (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [fbci_pkg::REG_ADDR_W-1:0] sw_addr,
    input wire logic [31:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [31:0] sw_rdata,
    output logic [fbci_pkg::ADDR_W-1:0] f_addr,
    input wire logic [fbci_pkg::DATA_W-1:0] f_dq_in,
    output logic [fbci_pkg::DATA_W-1:0] f_dq_out,
    output logic f_dq_oe,
    output logic f_ce_n,
    output logic f_oe_n,
    output logic f_we_n,
    output logic reset_powerdown_n,
    output logic program_supply_high
);

    typedef enum logic [2:0] {S_IDLE, S_CMD1, S_CMD2, S_READ, S_POLL, S_RP_LOW, S_WAKE} fbci_state_t;

    fbci_state_t state;
    fbci_pkg::fbci_op_t op;
    fbci_pkg::fbci_op_t next_op;
    fbci_pkg::fbci_req_t eng_word;
    logic eng_req;
    logic eng_done;
    logic [fbci_pkg::DATA_W-1:0] eng_rdata;
    logic [fbci_pkg::CNT_W-1:0] cnt;
    logic [fbci_pkg::ADDR_W-1:0] cmd_addr;
    logic [fbci_pkg::DATA_W-1:0] cmd_data;
    logic flash_busy;
    logic suspended;
    logic refused;
    logic seq_error;
    logic [7:0] flash_status;
    logic [fbci_pkg::DATA_W-1:0] result;
    logic cmd_write;
    logic op_ok;
    logic accept;
    logic done_ready;

    fbci_bus_cycle u_cycle (
        .clk(clk),
        .rst_b(rst_b),
        .req_valid(eng_req),
        .req(eng_word),
        .done(eng_done),
        .rdata(eng_rdata),
        .ce_n(f_ce_n),
        .oe_n(f_oe_n),
        .we_n(f_we_n),
        .addr(f_addr),
        .dq_out(f_dq_out),
        .dq_oe(f_dq_oe),
        .dq_in(f_dq_in)
    );

    function automatic logic [15:0] first_code(input fbci_pkg::fbci_op_t o);
        case (o)
            fbci_pkg::OP_READ_ARRAY: first_code = fbci_pkg::CMD_READ_ARRAY;
            fbci_pkg::OP_READ_IDENT: first_code = fbci_pkg::CMD_READ_IDENT;
            fbci_pkg::OP_READ_STATUS: first_code = fbci_pkg::CMD_READ_STATUS;
            fbci_pkg::OP_CLEAR_STATUS: first_code = fbci_pkg::CMD_CLEAR_STATUS;
            fbci_pkg::OP_ERASE: first_code = fbci_pkg::CMD_ERASE_SETUP;
            fbci_pkg::OP_WORD_WRITE: first_code = fbci_pkg::CMD_WORD_SETUP;
            fbci_pkg::OP_SUSPEND: first_code = fbci_pkg::CMD_SUSPEND;
            default: first_code = fbci_pkg::CMD_CONFIRM;
        endcase
    endfunction

    assign done_ready = eng_done && eng_rdata[fbci_pkg::ENGINE_READY_BIT];

    // Decide whether a command write is legal right now
    always_comb begin
        next_op = fbci_pkg::fbci_op_t'(sw_wdata[3:0]);
        cmd_write = sw_wr && (sw_addr == fbci_pkg::REG_CMD);
        op_ok = 1'b0;
        case (next_op)
            fbci_pkg::OP_READ_ARRAY,
            fbci_pkg::OP_READ_IDENT: op_ok = !flash_busy || suspended;
            fbci_pkg::OP_READ_STATUS: op_ok = 1'b1;
            // Clear has no effect while suspended, so it is not sent
            fbci_pkg::OP_CLEAR_STATUS: op_ok = !suspended;
            fbci_pkg::OP_ERASE,
            fbci_pkg::OP_WORD_WRITE: op_ok = program_supply_high && !flash_busy;
            fbci_pkg::OP_SUSPEND: op_ok = flash_busy && !suspended;
            fbci_pkg::OP_RESUME: op_ok = suspended;
            fbci_pkg::OP_RESET: op_ok = 1'b1;
            // unknown codes never reach the pins
            default: op_ok = 1'b0;
        endcase
        accept = cmd_write && op_ok && (state == S_IDLE);
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_addr <= '0;
            cmd_data <= '0;
            program_supply_high <= 1'b0;
        end else if (sw_wr) begin
            if (sw_addr == fbci_pkg::REG_ADDR) begin
                cmd_addr <= sw_wdata[fbci_pkg::ADDR_W-1:0];
            end else if (sw_addr == fbci_pkg::REG_WDATA) begin
                cmd_data <= sw_wdata[fbci_pkg::DATA_W-1:0];
            end else if (sw_addr == fbci_pkg::REG_CONFIG) begin
                program_supply_high <= sw_wdata[fbci_pkg::CFG_SUPPLY];
            end
        end
    end

    // Command sequencer; reset starts with the flash held in power-down
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= S_RP_LOW;
            op <= fbci_pkg::OP_RESET;
            cnt <= '0;
            eng_req <= 1'b0;
            eng_word <= '0;
        end else begin
            eng_req <= 1'b0;
            case (state)
                S_IDLE: begin
                    if (accept) begin
                        op <= next_op;
                        cnt <= '0;
                        if (next_op == fbci_pkg::OP_RESET) begin
                            state <= S_RP_LOW;
                        end else begin
                            eng_req <= 1'b1;
                            eng_word <= '{wr: 1'b1, addr: cmd_addr, data: first_code(next_op)};
                            state <= S_CMD1;
                        end
                    end
                end
                S_CMD1: begin
                    if (eng_done) begin
                        case (op)
                            fbci_pkg::OP_READ_ARRAY,
                            fbci_pkg::OP_READ_IDENT,
                            fbci_pkg::OP_READ_STATUS: begin
                                eng_req <= 1'b1;
                                eng_word <= '{wr: 1'b0, addr: cmd_addr, data: '0};
                                state <= S_READ;
                            end
                            fbci_pkg::OP_ERASE: begin
                                eng_req <= 1'b1;
                                eng_word <= '{wr: 1'b1, addr: cmd_addr, data: fbci_pkg::CMD_CONFIRM};
                                state <= S_CMD2;
                            end
                            fbci_pkg::OP_WORD_WRITE: begin
                                eng_req <= 1'b1;
                                eng_word <= '{wr: 1'b1, addr: cmd_addr, data: cmd_data};
                                state <= S_CMD2;
                            end
                            fbci_pkg::OP_SUSPEND: begin
                                eng_req <= 1'b1;
                                eng_word <= '{wr: 1'b0, addr: cmd_addr, data: '0};
                                state <= S_POLL;
                            end
                            default: state <= S_IDLE;
                        endcase
                    end
                end
                S_CMD2,
                S_READ: begin
                    if (eng_done) begin
                        state <= S_IDLE;
                    end
                end
                S_POLL: begin
                    if (done_ready) begin
                        state <= S_IDLE;
                    end else if (eng_done) begin
                        eng_req <= 1'b1;
                    end
                end
                S_RP_LOW: begin
                    if (cnt == fbci_pkg::CNT_W'(fbci_pkg::RESET_LOW_CYC - 1)) begin
                        cnt <= '0;
                        state <= S_WAKE;
                    end else begin
                        cnt <= cnt + fbci_pkg::CNT_W'(1);
                    end
                end
                default: begin
                    if (cnt == fbci_pkg::CNT_W'(fbci_pkg::WAKE_CYC - 1)) begin
                        state <= S_IDLE;
                    end else begin
                        cnt <= cnt + fbci_pkg::CNT_W'(1);
                    end
                end
            endcase
        end
    end

    // only logic levels, never high voltage
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reset_powerdown_n <= 1'b0;
        end else begin
            reset_powerdown_n <= (state != S_RP_LOW);
        end
    end

    // Mirror of what the flash is doing, kept from the commands sent and status seen
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flash_busy <= 1'b0;
            suspended <= 1'b0;
            flash_status <= fbci_pkg::FLASH_STATUS_WAKE;
            result <= '0;
        end else if (state == S_RP_LOW) begin
            flash_busy <= 1'b0;
            suspended <= 1'b0;
            flash_status <= fbci_pkg::FLASH_STATUS_WAKE;
        end else if (eng_done) begin
            if (state == S_CMD2) begin
                flash_busy <= 1'b1;
            end else if (state == S_CMD1 && op == fbci_pkg::OP_RESUME) begin
                suspended <= 1'b0;
            end else if (state == S_CMD1 && op == fbci_pkg::OP_CLEAR_STATUS) begin
                flash_status <= flash_status & ~fbci_pkg::FLASH_ERR_MASK;
            end else if (state == S_READ) begin
                result <= eng_rdata;
                if (op == fbci_pkg::OP_READ_STATUS) begin
                    flash_status <= eng_rdata[7:0];
                    if (eng_rdata[fbci_pkg::ENGINE_READY_BIT] && !suspended) begin
                        flash_busy <= 1'b0;
                    end
                end
            end else if (state == S_POLL) begin
                flash_status <= eng_rdata[7:0];
                result <= eng_rdata;
                if (eng_rdata[fbci_pkg::ENGINE_READY_BIT]) begin
                    suspended <= 1'b1;
                end
            end
        end
    end

    // Sticky controller flags; a new set outranks a clear in the same cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            refused <= 1'b0;
            seq_error <= 1'b0;
        end else begin
            if (cmd_write && !accept) begin
                refused <= 1'b1;
            end else if (accept) begin
                refused <= 1'b0;
            end
            // both fail bits mean bad sequence
            if (eng_done && state == S_READ && op == fbci_pkg::OP_READ_STATUS &&
                eng_rdata[fbci_pkg::ERASE_FAIL_BIT] && eng_rdata[fbci_pkg::WRITE_FAIL_BIT]) begin
                seq_error <= 1'b1;
            end else if (accept && next_op == fbci_pkg::OP_CLEAR_STATUS) begin
                seq_error <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sw_rdata <= '0;
        end else if (sw_rd) begin
            if (sw_addr == fbci_pkg::REG_ADDR) begin
                sw_rdata <= 32'(cmd_addr);
            end else if (sw_addr == fbci_pkg::REG_WDATA) begin
                sw_rdata <= 32'(cmd_data);
            end else if (sw_addr == fbci_pkg::REG_CONFIG) begin
                sw_rdata <= 32'(program_supply_high);
            end else if (sw_addr == fbci_pkg::REG_STATUS) begin
                sw_rdata <= '0;
                sw_rdata[fbci_pkg::ST_BUSY] <= (state != S_IDLE);
                sw_rdata[fbci_pkg::ST_REFUSED] <= refused;
                sw_rdata[fbci_pkg::ST_FLASH_BUSY] <= flash_busy;
                sw_rdata[fbci_pkg::ST_SUSPENDED] <= suspended;
                sw_rdata[fbci_pkg::ST_SEQ_ERROR] <= seq_error;
                sw_rdata[fbci_pkg::ST_FLASH_LSB +: 8] <= flash_status;
            end else if (sw_addr == fbci_pkg::REG_RESULT) begin
                sw_rdata <= 32'(result);
            end else begin
                sw_rdata <= '0;
            end
        end else begin
            sw_rdata <= '0;
        end
    end

endmodule

`default_nettype wire

// *** fbci_host_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module fbci_host_sva (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [fbci_pkg::ADDR_W-1:0] f_addr,
    input wire logic [fbci_pkg::DATA_W-1:0] f_dq_out,
    input wire logic f_dq_oe,
    input wire logic f_ce_n,
    input wire logic f_oe_n,
    input wire logic f_we_n,
    input wire logic reset_powerdown_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_we;
        !f_we_n ##1 !f_we_n ##1 (f_we_n && f_dq_oe && !f_ce_n) ##1 (f_ce_n && !f_dq_oe);
    endsequence
    sequence s_rd;
        !f_oe_n [*3] ##1 (f_oe_n && !f_ce_n) ##1 f_ce_n;
    endsequence
    property p_no_both;
        f_oe_n || f_we_n;
    endproperty
    a_no_both: assert property (p_no_both) else $error("oe and we low together");
    property p_oe_sel;
        !f_oe_n |-> !f_ce_n && !f_dq_oe && reset_powerdown_n;
    endproperty
    a_oe_sel: assert property (p_oe_sel) else $error("read without select");
    property p_we;
        $fell(f_we_n) |-> s_we;
    endproperty
    a_we: assert property (p_we) else $error("write cycle shape");
    property p_hold;
        $rose(f_we_n) |-> $stable(f_addr) && $stable(f_dq_out);
    endproperty
    a_hold: assert property (p_hold) else $error("write data moved");
    property p_rd;
        $fell(f_oe_n) |-> s_rd;
    endproperty
    a_rd: assert property (p_rd) else $error("read cycle shape");
    property p_rp_low;
        $fell(reset_powerdown_n) |-> !reset_powerdown_n [*2] ##1 reset_powerdown_n;
    endproperty
    a_rp_low: assert property (p_rp_low) else $error("reset pulse length");
    property p_wake;
        $rose(reset_powerdown_n) |-> f_ce_n [*8] ##1 f_ce_n [*8] ##1 f_ce_n [*4];
    endproperty
    a_wake: assert property (p_wake) else $error("access before wake");
    property p_pd_idle;
        !reset_powerdown_n |-> f_ce_n && f_we_n && f_oe_n && !f_dq_oe;
    endproperty
    a_pd_idle: assert property (p_pd_idle) else $error("bus active in power-down");
endmodule
bind fbci_host fbci_host_sva u_sva (.clk(clk), .rst_b(rst_b), .f_addr(f_addr), .f_dq_out(f_dq_out),
    .f_dq_oe(f_dq_oe), .f_ce_n(f_ce_n), .f_oe_n(f_oe_n), .f_we_n(f_we_n), .reset_powerdown_n(reset_powerdown_n));
`default_nettype wire

// *** fbci_host_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module fbci_host_test;
    // Arbitrary identifier values
    localparam logic [15:0] MAKER = 16'h0011;
    localparam logic [15:0] DEVICE = 16'h0022;
    logic clk = 1'b0, rst_b = 1'b0, sw_wr = 1'b0, sw_rd = 1'b0;
    logic [3:0] sw_addr = 4'h0;
    logic [31:0] sw_wdata = 32'h0, sw_rdata, d;
    logic [fbci_pkg::ADDR_W-1:0] f_addr;
    logic [15:0] f_dq_in, f_dq_out;
    logic f_dq_oe, f_ce_n, f_oe_n, f_we_n, rp_n, vpp;
    int n_mismatch = 0, compares = 0;
    initial forever #25 clk = ~clk;
    fbci_host DUT (.clk(clk), .rst_b(rst_b), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
        .sw_rdata(sw_rdata), .f_addr(f_addr), .f_dq_in(f_dq_in), .f_dq_out(f_dq_out), .f_dq_oe(f_dq_oe),
        .f_ce_n(f_ce_n), .f_oe_n(f_oe_n), .f_we_n(f_we_n), .reset_powerdown_n(rp_n), .program_supply_high(vpp));
    fbci_flash_model #(.MAKER(MAKER), .DEVICE(DEVICE)) u_flash (.addr(f_addr), .hdq(f_dq_out), .hoe(f_dq_oe),
        .ce_n(f_ce_n), .oe_n(f_oe_n), .we_n(f_we_n), .rp_n(rp_n), .vpp(vpp), .dq(f_dq_in));
    task automatic end_of_test;
        if (n_mismatch == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] exp, input logic [31:0] got, input string what);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        sw_wr <= 1'b1;
        sw_addr <= a;
        sw_wdata <= v;
        @(posedge clk);
        sw_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        sw_rd <= 1'b1;
        sw_addr <= a;
        @(posedge clk);
        sw_rd <= 1'b0;
        #1 d = sw_rdata;
    endtask
    task automatic idle;
        for (int i = 0; i < 300; i++) begin
            rd(fbci_pkg::REG_STATUS);
            if (d[fbci_pkg::ST_BUSY] === 1'b0)
                break;
        end
    endtask
    task automatic op(input logic [3:0] c);
        wr(fbci_pkg::REG_CMD, {28'h0, c});
        idle();
    endtask
    task automatic poll;
        for (int i = 0; i < 100; i++) begin
            op(4'd2);
            if (d[fbci_pkg::ST_FLASH_BUSY] === 1'b0)
                break;
        end
    endtask
    task automatic rd_at(input logic [18:0] a, input logic [3:0] c);
        wr(fbci_pkg::REG_ADDR, {13'h0, a});
        op(c);
        rd(fbci_pkg::REG_RESULT);
    endtask
    task automatic t_boot;
        idle();
        op(4'd2);
        chk(32'h80, {24'h0, d[15:8]}, "wake status");
        rd_at(19'h5, 4'd0);
        chk(32'ha505, d, "array read");
    endtask
    task automatic t_ident;
        rd_at(19'h0, 4'd1);
        chk({16'h0, MAKER}, d, "maker code");
        rd_at(19'h1, 4'd1);
        chk({16'h0, DEVICE}, d, "device code");
        rd_at(19'h1, 4'd0);
        chk(32'ha501, d, "back to array");
        op(4'd9);
        chk(32'h1, {31'h0, d[fbci_pkg::ST_REFUSED]}, "bad code");
        op(4'd3);
        chk(32'h0, {31'h0, d[fbci_pkg::ST_REFUSED]}, "clear status");
    endtask
    task automatic t_word;
        wr(fbci_pkg::REG_CONFIG, 32'h1);
        wr(fbci_pkg::REG_ADDR, 32'h7);
        wr(fbci_pkg::REG_WDATA, 32'h1234);
        op(4'd5);
        op(4'd0);
        chk(32'h1, {31'h0, d[fbci_pkg::ST_REFUSED]}, "array while busy");
        poll();
        rd_at(19'h7, 4'd0);
        chk(32'h1234, d, "word written");
    endtask
    task automatic t_erase;
        op(4'd4);
        op(4'd6);
        chk(32'h1, {31'h0, d[fbci_pkg::ST_SUSPENDED]}, "suspended");
        rd_at(19'h7, 4'd0);
        chk(32'h1234, d, "read in suspend");
        op(4'd7);
        poll();
        rd_at(19'h7, 4'd0);
        chk(32'hffff, d, "erased");
        wr(fbci_pkg::REG_CONFIG, 32'h0);
        op(4'd4);
        chk(32'h1, {31'h0, d[fbci_pkg::ST_REFUSED]}, "supply off");
    endtask
    task automatic t_abort;
        wr(fbci_pkg::REG_CONFIG, 32'h1);
        wr(fbci_pkg::REG_WDATA, 32'h5a5a);
        op(4'd5);
        op(4'd8);
        op(4'd2);
        chk(32'h80, {24'h0, d[15:8]}, "status after abort");
        rd_at(19'h7, 4'd0);
        chk(32'hffff, d, "aborted word");
    endtask
    task automatic t_lockout;
        wr(fbci_pkg::REG_CONFIG, 32'h1);
        wr(fbci_pkg::REG_CMD, 32'h4);
        // Supply drops between setup and confirm
        wr(fbci_pkg::REG_CONFIG, 32'h0);
        idle();
        op(4'd2);
        chk(32'ha8, {24'h0, d[15:8]}, "lockout status");
        chk(32'h0, {31'h0, d[fbci_pkg::ST_SEQ_ERROR]}, "no sequence error");
        op(4'd3);
        op(4'd2);
        chk(32'h80, {24'h0, d[15:8]}, "status cleared");
        rd(fbci_pkg::REG_CONFIG);
        chk(32'h0, d, "supply request");
    endtask
    task automatic t_sysreset;
        wr(fbci_pkg::REG_CONFIG, 32'h1);
        wr(fbci_pkg::REG_WDATA, 32'h0f0f);
        op(4'd5);
        // System reset mid-operation takes the flash down too
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        idle();
        op(4'd2);
        chk(32'h80, {24'h0, d[15:8]}, "status after system reset");
        rd_at(19'h7, 4'd0);
        chk(32'hffff, d, "word after system reset");
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        t_boot();
        t_ident();
        t_word();
        t_erase();
        t_abort();
        t_lockout();
        t_sysreset();
        end_of_test();
    end
    // Whole run needs well under this span
    initial begin
        #2000000;
        n_mismatch++;
        end_of_test();
    end
endmodule
`default_nettype wire

// *** fbci_pkg.sv ***
package fbci_pkg;

    // Clock and pin timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int ACCESS_NS = 120;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WE_PULSE_NS = 100;
    localparam int WE_PULSE_CYC = (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_LOW_NS = 100;
    localparam int RESET_LOW_CYC = (RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Wake interval before the next command; figure not fixed by the flash side
    localparam int WAKE_TO_WRITE_TIME_NS = 1000;
    localparam int WAKE_CYC = (WAKE_TO_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 8;

    // Widths
    localparam int ADDR_W = 19;
    localparam int DATA_W = 16;
    localparam int REG_ADDR_W = 4;

    // Controller register offsets
    localparam logic [3:0] REG_CMD = 4'h0;
    localparam logic [3:0] REG_ADDR = 4'h1;
    localparam logic [3:0] REG_WDATA = 4'h2;
    localparam logic [3:0] REG_CONFIG = 4'h3;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_RESULT = 4'h5;

    // Controller status and config field positions
    localparam int ST_BUSY = 0;
    localparam int ST_REFUSED = 1;
    localparam int ST_FLASH_BUSY = 2;
    localparam int ST_SUSPENDED = 3;
    localparam int ST_SEQ_ERROR = 4;
    localparam int ST_FLASH_LSB = 8;
    localparam int CFG_SUPPLY = 0;

    // Flash command codes
    localparam logic [15:0] CMD_READ_ARRAY = 16'h00ff;
    localparam logic [15:0] CMD_READ_IDENT = 16'h0090;
    localparam logic [15:0] CMD_READ_STATUS = 16'h0070;
    localparam logic [15:0] CMD_CLEAR_STATUS = 16'h0050;
    localparam logic [15:0] CMD_ERASE_SETUP = 16'h0020;
    localparam logic [15:0] CMD_CONFIRM = 16'h00d0;
    localparam logic [15:0] CMD_WORD_SETUP = 16'h0040;
    localparam logic [15:0] CMD_SUSPEND = 16'h00b0;

    // Flash status bits
    localparam int ENGINE_READY_BIT = 7;
    localparam int ERASE_FAIL_BIT = 5;
    localparam int WRITE_FAIL_BIT = 4;
    localparam int SUPPLY_FAIL_BIT = 3;
    localparam int PROTECT_FAIL_BIT = 1;
    localparam logic [7:0] FLASH_STATUS_WAKE = 8'h80;
    localparam logic [7:0] FLASH_ERR_MASK = 8'h3a;

    typedef enum logic [3:0] {
        OP_READ_ARRAY,
        OP_READ_IDENT,
        OP_READ_STATUS,
        OP_CLEAR_STATUS,
        OP_ERASE,
        OP_WORD_WRITE,
        OP_SUSPEND,
        OP_RESUME,
        OP_RESET
    } fbci_op_t;

    typedef struct packed {
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } fbci_req_t;

endpackage
